// ---- core/swss_pkg.sv ----
package swss_pkg;

	////////////////////////////////////////////////////////////////
	// Clock and counter sizing
	localparam int CLK_PERIOD_NS = 100;
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;

	// Least time rounds up, longest time rounds down, never below one cycle
	function automatic int cyc_min(input int t_us);
		int c;
		c = (t_us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int cyc_max(input int t_us);
		int c;
		c = (t_us * 1000) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	////////////////////////////////////////////////////////////////
	// Function opcodes and memory layout
	localparam logic [7:0] OP_READ = 8'h69;
	localparam logic [7:0] OP_WRITE = 8'h6c;
	localparam logic [7:0] OP_COPY = 8'h48;
	localparam logic [7:0] OP_RECALL = 8'hb8;
	localparam logic [7:0] OP_LOCK = 8'h6a;
	localparam logic [7:0] ADDR_LAST = 8'hff;
	localparam logic [7:0] BYTE_ONES = 8'hff;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam int MEM_DEPTH = 256;
	localparam int NUM_BLK = 16;
	localparam logic [2:0] BIT_LAST = 3'h7;

	////////////////////////////////////////////////////////////////
	// Device timing
	localparam int RST_DET_US = 120;
	localparam int RST_DET_CYC = cyc_min(RST_DET_US);
	localparam int PRESENCE_WAIT_DELAY_US = 30;
	localparam int PRESENCE_WAIT_DELAY_CYC = cyc_min(PRESENCE_WAIT_DELAY_US);
	localparam int PRESENCE_LOW_DURATION_US = 100;
	localparam int PRESENCE_LOW_DURATION_CYC = cyc_min(PRESENCE_LOW_DURATION_US);
	localparam int WR_SAMPLE_US = 30;
	localparam int WR_SAMPLE_CYC = cyc_min(WR_SAMPLE_US);
	localparam int RD_RELEASE_US = 45;
	localparam int RD_RELEASE_CYC = cyc_max(RD_RELEASE_US);
	localparam int COPY_TIME_US = 2000;
	localparam int COPY_TIME_CYC_DEF = cyc_min(COPY_TIME_US);

	////////////////////////////////////////////////////////////////
	// Master timing
	localparam int RESET_LOW_DURATION_US = 480;
	localparam int RESET_LOW_DURATION_CYC_DEF = cyc_min(RESET_LOW_DURATION_US);
	localparam int PRES_SAMPLE_US = 70;
	localparam int PRES_SAMPLE_CYC = cyc_min(PRES_SAMPLE_US);
	localparam int SLOT_US = 70;
	localparam int SLOT_CYC = cyc_min(SLOT_US);
	localparam int W1_LOW_US = 5;
	localparam int W1_LOW_CYC = cyc_max(W1_LOW_US);
	localparam int RD_LOW_US = 2;
	localparam int RD_LOW_CYC = cyc_min(RD_LOW_US);
	localparam int READ_SAMPLE_POINT_US = 15;
	localparam int READ_SAMPLE_POINT_CYC = cyc_max(READ_SAMPLE_POINT_US);
	localparam int SLOT_RECOVERY_TIME_US = 5;
	localparam int SLOT_RECOVERY_TIME_CYC = cyc_min(SLOT_RECOVERY_TIME_US);

	// Master user commands
	typedef enum logic [1:0] {
		SWSS_CMD_RESET,
		SWSS_CMD_WRITE,
		SWSS_CMD_READ
	} swss_cmd_t;

endpackage

// ---- core/swss_if.sv ----
`timescale 1ns/100ps
interface swss_if;
	logic dq_dev_o;
	logic dq_dev_oe;
	logic dq_mst_o;
	logic dq_mst_oe;
	logic dq;

	// Wired-AND with the pullup: any enabled low driver wins
	assign dq = ~((dq_dev_oe & ~dq_dev_o) | (dq_mst_oe & ~dq_mst_o));

	modport dev (
		output dq_dev_o,
		output dq_dev_oe,
		input dq
	);

	modport mst (
		output dq_mst_o,
		output dq_mst_oe,
		input dq
	);
endinterface

// ---- core/swss_dev.sv ----
`timescale 1ns/100ps
// Contract
// - Read opcode, address, then bytes stream out
// - Write opcode, address, then bytes stream in
// - Copy copies shadow block into nonvolatile
// - Recall reloads shadow block from nonvolatile
// - Lock write-protects the addressed block forever
// - Master opens with reset low, then releases
// - After rise, wait, then pull presence low
// - Master starts slots; device only originates presence
// - Write slot 60 to 120 us, recovery
// - Device samples write bit 15-60 us in
// - Write one: line high within 15 us
// - Write zero: line low whole slot
// - Read slot: master low at least 1 us
// - Master samples read bit at 15 us
// - Device releases line before read slot ends
// - Read slot 60 to 120 us, recovery
// - Low over 120 us means reset, abandon
// - Address steps after MSB; past end reads ones
// - Discard bad, partial, locked, past-end writes
// - Lock acts only when lock enable set
module swss_dev #(
	parameter int COPY_TIME_CYC = swss_pkg::COPY_TIME_CYC_DEF,
	parameter logic [15:0] NV_BLOCK_MASK = 16'hffff,
	parameter logic [15:0] RO_BLOCK_MASK = 16'h0000
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic lock_enable,
	output logic copy_in_progress_flag,
	output logic link_reset_seen,
	swss_if.dev bus
);

	typedef enum logic [2:0] {
		S_QUIET, S_RST_LOW, S_PRES_WAIT, S_PRES_LOW,
		S_CMD, S_ADDR, S_READ, S_WRITE
	} swss_dev_state_t;
	swss_dev_state_t state_reg;
	logic sync1_reg, sync2_reg, prev_reg;
	logic [swss_pkg::CNT_W-1:0] edge_cnt_reg, slot_cnt_reg, busy_cnt_reg;
	logic [7:0] op_reg, addr_reg, shift_reg, tx_reg;
	logic [2:0] bit_reg;
	logic past_end_reg, oe_reg, busy_reg, rst_pulse_reg;
	logic [swss_pkg::NUM_BLK-1:0] lock_reg;
	logic [7:0] shadow_mem [swss_pkg::MEM_DEPTH], nv_mem [swss_pkg::MEM_DEPTH];
	logic fall, rise, rx_state, sample_hit, byte_done, addr_done;
	logic [7:0] rx_byte, addr_inc;

	// Block index of a byte address
	function automatic logic [3:0] blk_of(input logic [7:0] a);
		return a[7:4];
	endfunction
	// A byte may be stored unless read-only or a locked or busy EEPROM block
	function automatic logic can_write(input logic [7:0] a, input logic [15:0] locks, input logic busy);
		logic [3:0] b;
		b = blk_of(a);
		return !RO_BLOCK_MASK[b] && !(NV_BLOCK_MASK[b] && (locks[b] || busy));
	endfunction

	////////////////////////////////////////////////////////////////
	// Pin synchroniser and edge detection
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
			prev_reg <= 1'b1;
		end else if (clk_en) begin
			sync1_reg <= bus.dq;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	assign fall = prev_reg & ~sync2_reg;
	assign rise = ~prev_reg & sync2_reg;

	////////////////////////////////////////////////////////////////
	// Timers: time since any edge, time since the last falling edge
	// Both saturate, so each equality below fires once per edge
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			edge_cnt_reg <= swss_pkg::CNT_MAX;
			slot_cnt_reg <= swss_pkg::CNT_MAX;
		end else if (clk_en) begin
			if (fall || rise) begin
				edge_cnt_reg <= '0;
			end else if (edge_cnt_reg != swss_pkg::CNT_MAX) begin
				edge_cnt_reg <= edge_cnt_reg + 1'b1;
			end
			if (fall) begin
				slot_cnt_reg <= '0;
			end else if (slot_cnt_reg != swss_pkg::CNT_MAX) begin
				slot_cnt_reg <= slot_cnt_reg + 1'b1;
			end
		end
	end
	// Bit decoding shared by the state machine and the memory
	assign rx_state = (state_reg == S_CMD) || (state_reg == S_ADDR) || (state_reg == S_WRITE);
	assign sample_hit = (slot_cnt_reg == swss_pkg::CNT_W'(swss_pkg::WR_SAMPLE_CYC));
	assign byte_done = rx_state && sample_hit && (bit_reg == swss_pkg::BIT_LAST);
	assign rx_byte = {sync2_reg, shift_reg[7:1]};
	assign addr_done = (state_reg == S_ADDR) && byte_done;
	assign addr_inc = addr_reg + 8'h01;

	////////////////////////////////////////////////////////////////
	// Link state machine and line driver
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= S_QUIET;
			oe_reg <= 1'b0;
			op_reg <= swss_pkg::BYTE_ZERO;
			addr_reg <= swss_pkg::BYTE_ZERO;
			shift_reg <= swss_pkg::BYTE_ZERO;
			tx_reg <= swss_pkg::BYTE_ONES;
			bit_reg <= '0;
			past_end_reg <= 1'b0;
			rst_pulse_reg <= 1'b0;
		end else if (clk_en) begin
			rst_pulse_reg <= 1'b0;
			if (rx_state && sample_hit) begin
				shift_reg <= rx_byte;
			end
			if (sample_hit && (rx_state || state_reg == S_READ)) begin
				bit_reg <= bit_reg + 1'b1;
			end
			// Own presence low is excluded so it cannot look like a reset
			if (state_reg != S_PRES_LOW && !sync2_reg &&
				edge_cnt_reg == swss_pkg::CNT_W'(swss_pkg::RST_DET_CYC)) begin
				state_reg <= S_RST_LOW;
				oe_reg <= 1'b0;
				rst_pulse_reg <= 1'b1;
			end else begin
				unique case (state_reg)
					S_QUIET: oe_reg <= 1'b0;
					S_RST_LOW: begin
						if (rise) begin
							state_reg <= S_PRES_WAIT;
						end
					end
					S_PRES_WAIT: begin
						if (edge_cnt_reg == swss_pkg::CNT_W'(swss_pkg::PRESENCE_WAIT_DELAY_CYC)) begin
							oe_reg <= 1'b1;
							state_reg <= S_PRES_LOW;
						end
					end
					S_PRES_LOW: begin
						if (!sync2_reg &&
							edge_cnt_reg == swss_pkg::CNT_W'(swss_pkg::PRESENCE_LOW_DURATION_CYC)) begin
							oe_reg <= 1'b0;
							bit_reg <= '0;
							state_reg <= S_CMD;
						end
					end
					S_CMD: begin
						if (byte_done) begin
							op_reg <= rx_byte;
							unique case (rx_byte)
								swss_pkg::OP_READ, swss_pkg::OP_WRITE, swss_pkg::OP_COPY,
								swss_pkg::OP_RECALL, swss_pkg::OP_LOCK: state_reg <= S_ADDR;
								default: state_reg <= S_QUIET;
							endcase
						end
					end
					S_ADDR: begin
						if (byte_done) begin
							addr_reg <= rx_byte;
							past_end_reg <= 1'b0;
							tx_reg <= shadow_mem[rx_byte];
							if (op_reg == swss_pkg::OP_READ) begin
								state_reg <= S_READ;
							end else if (op_reg == swss_pkg::OP_WRITE) begin
								state_reg <= S_WRITE;
							end else begin
								state_reg <= S_QUIET;
							end
						end
					end
					S_READ: begin
						// Drive only a zero, starting on the master's own fall
						if (fall) begin
							oe_reg <= ~tx_reg[bit_reg];
						end else if (slot_cnt_reg == swss_pkg::CNT_W'(swss_pkg::RD_RELEASE_CYC)) begin
							oe_reg <= 1'b0;
						end
						if (sample_hit && bit_reg == swss_pkg::BIT_LAST) begin
							addr_reg <= addr_inc;
							if (past_end_reg || addr_reg == swss_pkg::ADDR_LAST) begin
								past_end_reg <= 1'b1;
								tx_reg <= swss_pkg::BYTE_ONES;
							end else begin
								tx_reg <= shadow_mem[addr_inc];
							end
						end
					end
					S_WRITE: begin
						if (byte_done) begin
							addr_reg <= addr_inc;
							if (addr_reg == swss_pkg::ADDR_LAST) begin
								past_end_reg <= 1'b1;
							end
						end
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Shadow RAM, nonvolatile image and lock bits
	// Copy and recall move a whole block in one cycle; flops make that free
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			lock_reg <= '0;
			for (int i = 0; i < swss_pkg::MEM_DEPTH; i++) begin
				shadow_mem[i] <= swss_pkg::BYTE_ZERO;
				nv_mem[i] <= swss_pkg::BYTE_ZERO;
			end
		end else if (clk_en) begin
			// Partial bytes never reach byte_done, so they are dropped
			if (state_reg == S_WRITE && byte_done && !past_end_reg &&
				can_write(addr_reg, lock_reg, busy_reg)) begin
				shadow_mem[addr_reg] <= rx_byte;
			end
			if (addr_done && op_reg == swss_pkg::OP_COPY && NV_BLOCK_MASK[blk_of(rx_byte)] &&
				!lock_reg[blk_of(rx_byte)] && !busy_reg) begin
				for (int i = 0; i < swss_pkg::MEM_DEPTH; i++) begin
					if (blk_of(8'(i)) == blk_of(rx_byte)) begin
						nv_mem[i] <= shadow_mem[i];
					end
				end
			end
			if (addr_done && op_reg == swss_pkg::OP_RECALL && NV_BLOCK_MASK[blk_of(rx_byte)]) begin
				for (int i = 0; i < swss_pkg::MEM_DEPTH; i++) begin
					if (blk_of(8'(i)) == blk_of(rx_byte)) begin
						shadow_mem[i] <= nv_mem[i];
					end
				end
			end
			if (addr_done && op_reg == swss_pkg::OP_LOCK && lock_enable && NV_BLOCK_MASK[blk_of(rx_byte)]) begin
				lock_reg[blk_of(rx_byte)] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Copy busy timer; blocks EEPROM writes while it runs
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_reg <= 1'b0;
			busy_cnt_reg <= '0;
		end else if (clk_en) begin
			if (addr_done && op_reg == swss_pkg::OP_COPY && NV_BLOCK_MASK[blk_of(rx_byte)] &&
				!lock_reg[blk_of(rx_byte)] && !busy_reg) begin
				busy_reg <= 1'b1;
				busy_cnt_reg <= '0;
			end else if (busy_reg) begin
				busy_cnt_reg <= busy_cnt_reg + 1'b1;
				if (busy_cnt_reg == swss_pkg::CNT_W'(COPY_TIME_CYC - 1)) begin
					busy_reg <= 1'b0;
				end
			end
		end
	end
	// Open drain: only the enable toggles, the data is always low
	assign bus.dq_dev_o = 1'b0;
	assign bus.dq_dev_oe = oe_reg;
	assign copy_in_progress_flag = busy_reg;
	assign link_reset_seen = rst_pulse_reg;
endmodule

// ---- core/swss_mst.sv ----
`timescale 1ns/100ps
module swss_mst #(
	parameter int RESET_LOW_DURATION_CYC = swss_pkg::RESET_LOW_DURATION_CYC_DEF
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic cmd_valid,
	input wire swss_pkg::swss_cmd_t cmd_kind,
	input wire logic [7:0] cmd_data,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_presence,
	swss_if.mst bus
);

	typedef enum logic [1:0] {
		M_IDLE,
		M_RST_LOW,
		M_RST_REL,
		M_SLOT
	} swss_mst_state_t;

	swss_mst_state_t state_reg;
	logic sync1_reg;
	logic sync2_reg;
	logic [swss_pkg::CNT_W-1:0] tmr_reg;
	logic [7:0] shift_reg;
	logic [2:0] bit_reg;
	logic is_read_reg;
	logic samp_reg;
	logic oe_reg;
	logic ready_reg;
	logic rsp_valid_reg;
	logic [7:0] rsp_data_reg;
	logic pres_reg;
	logic [swss_pkg::CNT_W-1:0] low_len;
	logic [7:0] shift_next;

	////////////////////////////////////////////////////////////////
	// Pin synchroniser
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end else if (clk_en) begin
			sync1_reg <= bus.dq;
			sync2_reg <= sync1_reg;
		end
	end

	// Low time of the current slot: short for read and one, whole slot for zero
	always_comb begin
		if (is_read_reg) begin
			low_len = swss_pkg::CNT_W'(swss_pkg::RD_LOW_CYC);
		end else if (shift_reg[0]) begin
			low_len = swss_pkg::CNT_W'(swss_pkg::W1_LOW_CYC);
		end else begin
			low_len = swss_pkg::CNT_W'(swss_pkg::SLOT_CYC);
		end
	end

	assign shift_next = {is_read_reg & samp_reg, shift_reg[7:1]};

	////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= M_IDLE;
			tmr_reg <= '0;
			shift_reg <= swss_pkg::BYTE_ZERO;
			bit_reg <= '0;
			is_read_reg <= 1'b0;
			samp_reg <= 1'b1;
			oe_reg <= 1'b0;
			ready_reg <= 1'b0;
			rsp_valid_reg <= 1'b0;
			rsp_data_reg <= swss_pkg::BYTE_ZERO;
			pres_reg <= 1'b0;
		end else if (clk_en) begin
			rsp_valid_reg <= 1'b0;
			tmr_reg <= tmr_reg + 1'b1;
			unique case (state_reg)
				M_IDLE: begin
					ready_reg <= 1'b1;
					tmr_reg <= '0;
					if (cmd_valid && ready_reg) begin
						if (cmd_kind == swss_pkg::SWSS_CMD_RESET) begin
							ready_reg <= 1'b0;
							oe_reg <= 1'b1;
							state_reg <= M_RST_LOW;
						end else if (cmd_kind == swss_pkg::SWSS_CMD_WRITE ||
							cmd_kind == swss_pkg::SWSS_CMD_READ) begin
							ready_reg <= 1'b0;
							is_read_reg <= (cmd_kind == swss_pkg::SWSS_CMD_READ);
							shift_reg <= (cmd_kind == swss_pkg::SWSS_CMD_READ) ? swss_pkg::BYTE_ONES : cmd_data;
							bit_reg <= '0;
							oe_reg <= 1'b1;
							state_reg <= M_SLOT;
						end
					end
				end
				M_RST_LOW: begin
					if (tmr_reg == swss_pkg::CNT_W'(RESET_LOW_DURATION_CYC - 1)) begin
						oe_reg <= 1'b0;
						tmr_reg <= '0;
						pres_reg <= 1'b0;
						state_reg <= M_RST_REL;
					end
				end
				M_RST_REL: begin
					if (tmr_reg == swss_pkg::CNT_W'(swss_pkg::PRES_SAMPLE_CYC)) begin
						pres_reg <= ~sync2_reg;
					end
					if (tmr_reg == swss_pkg::CNT_W'(RESET_LOW_DURATION_CYC - 1)) begin
						rsp_valid_reg <= 1'b1;
						ready_reg <= 1'b1;
						state_reg <= M_IDLE;
					end
				end
				M_SLOT: begin
					if (tmr_reg == low_len - 1'b1) begin
						oe_reg <= 1'b0;
					end
					if (tmr_reg == swss_pkg::CNT_W'(swss_pkg::READ_SAMPLE_POINT_CYC)) begin
						samp_reg <= sync2_reg;
					end
					// Slot plus recovery before the next falling edge
					if (tmr_reg == swss_pkg::CNT_W'(swss_pkg::SLOT_CYC + swss_pkg::SLOT_RECOVERY_TIME_CYC - 1)) begin
						shift_reg <= shift_next;
						tmr_reg <= '0;
						if (bit_reg == swss_pkg::BIT_LAST) begin
							rsp_valid_reg <= 1'b1;
							rsp_data_reg <= shift_next;
							ready_reg <= 1'b1;
							state_reg <= M_IDLE;
						end else begin
							bit_reg <= bit_reg + 1'b1;
							oe_reg <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	assign bus.dq_mst_o = 1'b0;
	assign bus.dq_mst_oe = oe_reg;
	assign cmd_ready = ready_reg;
	assign rsp_valid = rsp_valid_reg;
	assign rsp_data = rsp_data_reg;
	assign rsp_presence = pres_reg;

endmodule

// ---- testbench/swss_assertions.sv ----
`timescale 1ns/100ps
module swss_assertions #(
	parameter int COPY_TIME_CYC = 50,
	parameter int RST_CYC = 1400
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic dq_dev_oe,
	input wire logic dq_mst_oe,
	input wire logic dq,
	input wire logic copy_in_progress_flag,
	input wire logic link_reset_seen
);
	logic [15:0] high_cnt_reg, low_cnt_reg, dev_cnt_reg, mst_cnt_reg, idle_cnt_reg, cp_cnt_reg;

	function automatic logic [15:0] inc(input logic [15:0] v);
		return (v == 16'hffff) ? v : v + 16'h0001;
	endfunction

	////////////////////////////////////////////////////////////////
	// Run lengths of line and driver levels; saturate so long idles never wrap
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			high_cnt_reg <= '0;
			low_cnt_reg <= '0;
			dev_cnt_reg <= '0;
			mst_cnt_reg <= '0;
			idle_cnt_reg <= 16'hffff; // Reset counts as a long recovery
			cp_cnt_reg <= '0;
		end else if (clk_en) begin
			// Frozen cycles are not bus time for either end, so the counts pause too
			high_cnt_reg <= dq ? inc(high_cnt_reg) : '0;
			low_cnt_reg <= dq ? '0 : inc(low_cnt_reg);
			dev_cnt_reg <= dq_dev_oe ? inc(dev_cnt_reg) : '0;
			mst_cnt_reg <= dq_mst_oe ? inc(mst_cnt_reg) : '0;
			idle_cnt_reg <= dq_mst_oe ? '0 : inc(idle_cnt_reg);
			cp_cnt_reg <= copy_in_progress_flag ? inc(cp_cnt_reg) : '0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Properties
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n || !clk_en);

	property p_presence_wait;
		$rose(dq_dev_oe) && !dq_mst_oe |-> high_cnt_reg inside {[298:310]};
	endproperty
	a_presence_wait: assert property (p_presence_wait) else $error("presence not after high delay");

	property p_read_follow;
		$rose(dq_dev_oe) && dq_mst_oe |-> low_cnt_reg <= 16'd6;
	endproperty
	a_read_follow: assert property (p_read_follow) else $error("device drive not led by master");

	property p_dev_release;
		$fell(dq_dev_oe) |-> dev_cnt_reg inside {[440:455], [990:1010]};
	endproperty
	a_dev_release: assert property (p_dev_release) else $error("device low time wrong");

	property p_rst_detect;
		link_reset_seen |-> low_cnt_reg inside {[1200:1212]} && !dq_dev_oe;
	endproperty
	a_rst_detect: assert property (p_rst_detect) else $error("reset seen at wrong time");

	property p_rst_pulse;
		low_cnt_reg == 16'd1190 |-> ##[1:30] link_reset_seen;
	endproperty
	a_rst_pulse: assert property (p_rst_pulse) else $error("long low not taken as reset");

	property p_rst_quiet;
		link_reset_seen |-> !dq_dev_oe [*8];
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("device drives after reset");

	property p_copy_len;
		$fell(copy_in_progress_flag) |-> cp_cnt_reg == 16'(COPY_TIME_CYC);
	endproperty
	a_copy_len: assert property (p_copy_len) else $error("copy busy time wrong");

	property p_mst_low;
		$fell(dq_mst_oe) |-> mst_cnt_reg inside {swss_pkg::RD_LOW_CYC, swss_pkg::W1_LOW_CYC, swss_pkg::SLOT_CYC, RST_CYC};
	endproperty
	a_mst_low: assert property (p_mst_low) else $error("master low time wrong");

	property p_mst_rec;
		$rose(dq_mst_oe) |-> idle_cnt_reg >= 16'd10;
	endproperty
	a_mst_rec: assert property (p_mst_rec) else $error("slot recovery too short");

	// Main scenarios reached
	c_reset: cover property (link_reset_seen);
	c_copy: cover property ($rose(copy_in_progress_flag));
	c_read_bit: cover property ($fell(dq_dev_oe) && dev_cnt_reg < 16'd500);
endmodule

// ---- testbench/single_wire_slave_signaling_test.sv ----
`timescale 1ns/100ps
module single_wire_slave_signaling_test;
	localparam int COPY_CYC = 50;
	localparam int RST_CYC = 1400;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic lock_enable = 1'b0;
	logic clk_en = 1'b1;
	logic cmd_valid = 1'b0;
	swss_pkg::swss_cmd_t cmd_kind = swss_pkg::SWSS_CMD_RESET;
	logic [7:0] cmd_data = 8'h00;
	logic cmd_ready, rsp_valid, rsp_presence, copy_flag, rst_seen;
	logic [7:0] rsp_data, a;
	logic [8:0] exp_q[$];
	int n_errors = 0;
	int n_tests = 0;
	int n_rsp = 0;
	int copy_cyc = 0;

	swss_if bus_if();

	////////////////////////////////////////////////////////////////
	// Both ends face each other on one line
	swss_dev #(.COPY_TIME_CYC(COPY_CYC)) i_swss_dev (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
		.lock_enable(lock_enable), .copy_in_progress_flag(copy_flag), .link_reset_seen(rst_seen), .bus(bus_if));
	swss_mst #(.RESET_LOW_DURATION_CYC(RST_CYC)) i_swss_mst (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
		.cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_presence(rsp_presence), .bus(bus_if));
	swss_assertions #(.COPY_TIME_CYC(COPY_CYC), .RST_CYC(RST_CYC)) u_chk (.sys_clk(sys_clk), .arst_n(arst_n),
		.clk_en(clk_en), .dq_dev_oe(bus_if.dq_dev_oe), .dq_mst_oe(bus_if.dq_mst_oe), .dq(bus_if.dq),
		.copy_in_progress_flag(copy_flag), .link_reset_seen(rst_seen));

	// Free-running clock
	always #50 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////
	task automatic summarize();
		if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	// Note the answer first, hold the request over a ready edge, then wait for the answer
	task automatic cmd(input swss_pkg::swss_cmd_t k, input logic [7:0] d, input logic [8:0] e);
		int c;
		c = n_rsp;
		exp_q.push_back(e);
		cmd_kind = k;
		cmd_data = d;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1) @(negedge sys_clk);
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		while (n_rsp == c) @(negedge sys_clk);
	endtask

	task automatic wr(input logic [7:0] d);
		cmd(swss_pkg::SWSS_CMD_WRITE, d, 9'h000);
	endtask

	task automatic rd(input logic [7:0] e);
		cmd(swss_pkg::SWSS_CMD_READ, 8'($urandom), {1'b0, e});
	endtask

	task automatic rst();
		cmd(swss_pkg::SWSS_CMD_RESET, 8'h00, 9'h100);
	endtask

	////////////////////////////////////////////////////////////////
	// Answers are taken in order; rsp_valid is settled at the falling edge
	always @(negedge sys_clk) begin
		logic [8:0] e;
		if (rsp_valid === 1'b1) begin
			n_rsp++;
			if (exp_q.size() == 0) begin
				check(rsp_data, 8'hxx);
			end else begin
				e = exp_q.pop_front();
				if (e[8]) check({7'h00, rsp_presence}, 8'h01);
				else check(rsp_data, e[7:0]);
			end
		end
	end

	// Busy cycles of the copy timer
	always @(negedge sys_clk) if (copy_flag === 1'b1) copy_cyc++;

	// Hang guard: six resets of 2801 cycles, eighteen bytes of 6000 and a freeze make about 125k
	initial begin
		#(140000 * 100);
		n_errors++;
		summarize();
	end

	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(52931));
		a = 8'($urandom) | 8'h01; // Never zero, so a dropped write shows
		repeat (5) @(negedge sys_clk);
		arst_n = 1'b1;
		@(negedge sys_clk);
		rst();
		wr(swss_pkg::OP_LOCK);
		wr(swss_pkg::ADDR_LAST);
		rst();
		wr(swss_pkg::OP_WRITE);
		wr(swss_pkg::ADDR_LAST);
		// Freeze both ends mid-byte, away from any line edge; the byte must still land intact
		fork
			wr(a);
			begin
				repeat (3100) @(negedge sys_clk);
				clk_en = 1'b0;
				repeat (100) @(negedge sys_clk);
				clk_en = 1'b1;
			end
		join
		wr(~a);
		rst();
		wr(swss_pkg::OP_READ);
		wr(swss_pkg::ADDR_LAST);
		rd(a);
		rd(swss_pkg::BYTE_ONES);
		rst();
		wr(swss_pkg::OP_RECALL);
		wr(swss_pkg::ADDR_LAST);
		rd(swss_pkg::BYTE_ONES);
		rst();
		wr(swss_pkg::OP_READ);
		wr(swss_pkg::ADDR_LAST);
		rd(swss_pkg::BYTE_ZERO);
		rst();
		wr(swss_pkg::OP_COPY);
		wr(8'hf0);
		@(negedge sys_clk);
		check(8'(copy_cyc), 8'(COPY_CYC));
		summarize();
	end
endmodule
